// *** design/ielp_pkg.sv ***
// Shared constants for the interrupt-enable and low-power control registers.
// Assumes a 32-bit classic Wishbone master and a 100 MHz register clock.

package ielp_pkg;

   // ==========================================================================
   // Register indices (byte address is four times the index)
   localparam logic [7:0] IDX_IRQ_EN    = 8'hb4;
   localparam logic [7:0] IDX_LP_CTRL   = 8'hb5;
   localparam logic [7:0] IDX_PIN_CFG   = 8'hc0;
   localparam logic [7:0] IDX_IRQ_STAT  = 8'hc1;
   localparam logic [7:0] IDX_IRQ_MASK  = 8'hc2;
   localparam logic [7:0] IDX_LP_STAT   = 8'hc3;

   // ==========================================================================
   // Interrupt enable layout; status and mask share the event bits
   localparam int         IE_FORCE_EN   = 7;
   localparam int         IE_FORCE_LVL  = 6;
   localparam int         IE_CHARGER    = 5;
   localparam int         IE_ATTACH     = 3;
   localparam int         IE_OVERVOLT   = 1;
   localparam logic [7:0] IE_WMASK      = 8'hea;
   localparam logic [7:0] IE_RESET      = 8'h00;
   localparam logic [7:0] EVT_MASK      = 8'h2a;

   // ==========================================================================
   // Frame low-power control layout
   localparam int         LP_HOST       = 7;
   localparam int         LP_PERIPH     = 6;
   localparam int         LP_THR_HI     = 3;
   localparam int         LP_THR_LO     = 2;
   localparam int         LP_RESP       = 1;
   localparam logic [7:0] LP_WMASK      = 8'hce;
   localparam logic [7:0] LP_RSVD_VAL   = 8'h20;
   localparam logic [7:0] LP_RESET      = 8'ha2;

   // ==========================================================================
   // Pin configuration and low-power status layout
   localparam int         PIN_PUSH_PULL = 1;
   localparam int         PIN_ACT_LOW   = 0;
   localparam logic [7:0] PIN_WMASK     = 8'h03;
   localparam logic [7:0] PIN_RESET     = 8'h00;
   localparam int         LS_FRAME      = 0;
   localparam int         LS_RESP       = 1;
   localparam int         LS_HOST       = 2;

   // ==========================================================================
   // Timing: frame length in ns and its cycle count
   localparam int         CLK_PERIOD_NS = 10;
   localparam int         FRAME_TIME_NS = 125000;
   localparam int         FRAME_CYCLES  = FRAME_TIME_NS / CLK_PERIOD_NS;
   localparam int         THR_SHIFT_MAX = 5;

   // ==========================================================================
   // Bus answer state
   typedef enum logic [1:0]
   {
      BUS_IDLE = 2'b01,
      BUS_ACK  = 2'b10
   } ielp_bus_state_t;

endpackage : ielp_pkg

// *** design/ielp_pin_drv.sv ***
// Output stage of the interrupt pin: open-drain or push-pull drive.
// Assumes the pad resolves the wire from o_pin_out and o_pin_oe.

module ielp_pin_drv
   import ielp_pkg::*;
(
   input  wire logic i_clock,
   input  wire logic i_reset_n,
   input  wire logic i_clk_en,
   input  wire logic i_force_en,
   input  wire logic i_force_level,
   input  wire logic i_irq_level,
   input  wire logic i_push_pull,
   input  wire logic i_active_low,
   output logic      o_pin_out,
   output logic      o_pin_oe
);

   logic asserted;

   // ==========================================================================
   // Level selection
   always_comb
   begin
      asserted = i_force_en ? i_force_level : i_irq_level;
   end

   // ==========================================================================
   // Pad drive; open-drain only ever pulls low
   always_ff @(posedge i_clock)
   begin
      if (!i_reset_n)
      begin
         o_pin_out <= 1'b0;
         o_pin_oe  <= 1'b0;
      end
      else if (i_clk_en)
      begin
         if (i_push_pull)
         begin
            o_pin_out <= asserted ^ i_active_low;
            o_pin_oe  <= 1'b1;
         end
         else
         begin
            o_pin_out <= 1'b0;
            o_pin_oe  <= asserted;
         end
      end
   end

endmodule : ielp_pin_drv

// *** design/ielp_regs.sv ***
// Interrupt-enable and frame low-power control registers with pin drive.
// Assumes a classic Wishbone master on i_clock; event and idle inputs are
// asynchronous pins; the defaults word is stable while reset is low.

module ielp_regs
   import ielp_pkg::*;
#(
   parameter int FRAME_LEN = FRAME_CYCLES,
   parameter int CNT_W     = $clog2(FRAME_LEN + 1)
)
(
   input  wire logic        i_clock,
   input  wire logic        i_reset_n,
   input  wire logic        i_clk_en,
   input  wire logic        i_wb_cyc,
   input  wire logic        i_wb_stb,
   input  wire logic        i_wb_we,
   input  wire logic [11:0] i_wb_adr,
   input  wire logic [3:0]  i_wb_sel,
   input  wire logic [31:0] i_wb_dat,
   output logic      [31:0] o_wb_dat,
   output logic             o_wb_ack,
   input  wire logic [7:0]  i_otp_lp_default,
   input  wire logic        i_attach_seen,
   input  wire logic        i_overvoltage,
   input  wire logic        i_charger_found,
   input  wire logic        i_eds_powered_down,
   input  wire logic        i_bus_idle,
   input  wire logic        i_host_role,
   output logic             o_irq,
   output logic             o_pin_out,
   output logic             o_pin_oe,
   output logic             o_attach_watch,
   output logic             o_frame_sleep,
   output logic             o_response_sleep
);

   ielp_bus_state_t  bus_state;
   logic [7:0]       irq_en;
   logic [7:0]       lp_ctrl;
   logic [7:0]       pin_cfg;
   logic [7:0]       irq_stat;
   logic [7:0]       irq_mask;
   logic [5:0]       sync_a;
   logic [5:0]       sync_b;
   logic [2:0]       evt_prev;
   logic [CNT_W-1:0] idle_cnt;
   logic             wr_fire;
   logic             irq_level;
   logic [7:0]       evt_set;
   logic [7:0]       next_stat;
   logic [7:0]       wdata;
   logic             sleep_allowed;

   // ==========================================================================
   // Helpers
   function automatic logic hit(input logic [11:0] adr, input logic [7:0] idx);
      hit = (adr[11:2] == {2'b00, idx});
   endfunction : hit

   function automatic logic [CNT_W-1:0] idle_limit(input logic [1:0] code);
      idle_limit = CNT_W'(FRAME_LEN >> (THR_SHIFT_MAX - int'(code)));
   endfunction : idle_limit

   // ==========================================================================
   // Pin inputs: two flops before use
   always_ff @(posedge i_clock)
   begin
      if (!i_reset_n)
      begin
         sync_a   <= 6'h00;
         sync_b   <= 6'h00;
         evt_prev <= 3'h0;
      end
      else if (i_clk_en)
      begin
         sync_a   <= {i_host_role, i_bus_idle, i_eds_powered_down,
                      i_charger_found, i_overvoltage, i_attach_seen};
         sync_b   <= sync_a;
         evt_prev <= sync_b[2:0];
      end
   end

   // ==========================================================================
   // Wishbone slave: answer one cycle after the request
   assign wdata   = i_wb_dat[7:0];
   assign wr_fire = o_wb_ack && i_wb_cyc && i_wb_stb && i_wb_we && i_wb_sel[0];

   always_ff @(posedge i_clock)
   begin
      if (!i_reset_n)
      begin
         bus_state <= BUS_IDLE;
         o_wb_ack  <= 1'b0;
         o_wb_dat  <= 32'h00000000;
      end
      else if (i_clk_en)
      begin
         case (bus_state)
            BUS_IDLE:
            begin
               if (i_wb_cyc && i_wb_stb)
               begin
                  bus_state <= BUS_ACK;
                  o_wb_ack  <= 1'b1;
                  // Unmapped words answer with zero rather than an error
                  if (hit(i_wb_adr, IDX_IRQ_EN))
                     o_wb_dat <= {24'h000000, irq_en};
                  else if (hit(i_wb_adr, IDX_LP_CTRL))
                     o_wb_dat <= {24'h000000, lp_ctrl};
                  else if (hit(i_wb_adr, IDX_PIN_CFG))
                     o_wb_dat <= {24'h000000, pin_cfg};
                  else if (hit(i_wb_adr, IDX_IRQ_STAT))
                     o_wb_dat <= {24'h000000, irq_stat};
                  else if (hit(i_wb_adr, IDX_IRQ_MASK))
                     o_wb_dat <= {24'h000000, irq_mask};
                  else if (hit(i_wb_adr, IDX_LP_STAT))
                     o_wb_dat <= {29'h0, sync_b[5], o_response_sleep,
                                  o_frame_sleep};
                  else
                     o_wb_dat <= 32'h00000000;
               end
            end
            BUS_ACK:
            begin
               bus_state <= BUS_IDLE;
               o_wb_ack  <= 1'b0;
            end
            default:
            begin
               bus_state <= BUS_IDLE;
               o_wb_ack  <= 1'b0;
            end
         endcase
      end
   end

   // ==========================================================================
   // Software registers
   always_ff @(posedge i_clock)
   begin
      if (!i_reset_n)
      begin
         irq_en   <= IE_RESET;
         pin_cfg  <= PIN_RESET;
         irq_mask <= 8'h00;
         // Defaults word replaces the nominal reset value
         lp_ctrl  <= (i_otp_lp_default & LP_WMASK) | LP_RSVD_VAL;
      end
      else if (i_clk_en && wr_fire)
      begin
         if (hit(i_wb_adr, IDX_IRQ_EN))
            irq_en <= wdata & IE_WMASK;
         if (hit(i_wb_adr, IDX_LP_CTRL))
            lp_ctrl <= (wdata & LP_WMASK) | LP_RSVD_VAL;
         if (hit(i_wb_adr, IDX_PIN_CFG))
            pin_cfg <= wdata & PIN_WMASK;
         if (hit(i_wb_adr, IDX_IRQ_MASK))
            irq_mask <= wdata & EVT_MASK;
      end
   end

   // ==========================================================================
   // Sticky status; a new event wins over a write-one clear
   always_comb
   begin
      evt_set                = 8'h00;
      evt_set[IE_ATTACH]     = sync_b[0] && !evt_prev[0] && irq_en[IE_ATTACH]
                               && sync_b[3];
      evt_set[IE_OVERVOLT]   = sync_b[1] && !evt_prev[1]
                               && irq_en[IE_OVERVOLT];
      evt_set[IE_CHARGER]    = sync_b[2] && !evt_prev[2] && irq_en[IE_CHARGER];
      next_stat              = irq_stat;
      if (wr_fire && hit(i_wb_adr, IDX_IRQ_STAT))
         next_stat = irq_stat & ~wdata;
      next_stat = (next_stat | evt_set) & EVT_MASK;
   end

   always_ff @(posedge i_clock)
   begin
      if (!i_reset_n)
         irq_stat <= 8'h00;
      else if (i_clk_en)
         irq_stat <= next_stat;
   end

   assign irq_level = |(irq_stat & irq_mask);

   always_ff @(posedge i_clock)
   begin
      if (!i_reset_n)
      begin
         o_irq          <= 1'b0;
         o_attach_watch <= 1'b0;
      end
      else if (i_clk_en)
      begin
         o_irq          <= irq_level;
         o_attach_watch <= irq_en[IE_ATTACH] && sync_b[3];
      end
   end

   // ==========================================================================
   // Interrupt pin
   ielp_pin_drv u_pin
   (
      .i_clock       (i_clock),
      .i_reset_n     (i_reset_n),
      .i_clk_en      (i_clk_en),
      .i_force_en    (irq_en[IE_FORCE_EN]),
      .i_force_level (irq_en[IE_FORCE_LVL]),
      .i_irq_level   (irq_level),
      .i_push_pull   (pin_cfg[PIN_PUSH_PULL]),
      .i_active_low  (pin_cfg[PIN_ACT_LOW]),
      .o_pin_out     (o_pin_out),
      .o_pin_oe      (o_pin_oe)
   );

   // ==========================================================================
   // Low-power control; the idle count saturates at one frame
   assign sleep_allowed = sync_b[5] ? lp_ctrl[LP_HOST]
                                    : lp_ctrl[LP_PERIPH];

   always_ff @(posedge i_clock)
   begin
      if (!i_reset_n)
      begin
         idle_cnt         <= '0;
         o_frame_sleep    <= 1'b0;
         o_response_sleep <= 1'b0;
      end
      else if (i_clk_en)
      begin
         if (!sync_b[4])
            idle_cnt <= '0;
         else if (idle_cnt < CNT_W'(FRAME_LEN))
            idle_cnt <= idle_cnt + 1'b1;
         o_frame_sleep <= sleep_allowed && sync_b[4] && idle_cnt >=
                          idle_limit(lp_ctrl[LP_THR_HI:LP_THR_LO]);
         o_response_sleep <= lp_ctrl[LP_RESP];
      end
   end

   // ==========================================================================
   // Checks
   sequence s_wb_req;
      i_clk_en && i_wb_cyc && i_wb_stb && bus_state == BUS_IDLE;
   endsequence

   a_wb_answer: assert property (@(posedge i_clock) disable iff (!i_reset_n)
      s_wb_req |=> o_wb_ack ##1 (!o_wb_ack || !$past(i_clk_en)))
      else $error("Bus answer not a single cycle");

   a_force_level: assert property (@(posedge i_clock)
      disable iff (!i_reset_n)
      i_clk_en && irq_en[IE_FORCE_EN] && pin_cfg[PIN_PUSH_PULL]
      |=> o_pin_oe && o_pin_out ==
          ($past(irq_en[IE_FORCE_LVL]) ^ $past(pin_cfg[PIN_ACT_LOW])))
      else $error("Forced pin level wrong");

   a_force_hides_irq: assert property (@(posedge i_clock)
      disable iff (!i_reset_n)
      i_clk_en && irq_en[IE_FORCE_EN] && !irq_en[IE_FORCE_LVL]
      && !pin_cfg[PIN_PUSH_PULL] && irq_level |=> !o_pin_oe)
      else $error("Interrupt reached pin while forced");

   a_open_drain_low: assert property (@(posedge i_clock)
      disable iff (!i_reset_n)
      i_clk_en && !pin_cfg[PIN_PUSH_PULL] && !irq_en[IE_FORCE_EN]
      && irq_level |=> o_pin_oe && !o_pin_out)
      else $error("Open-drain assert not pulled low");

   a_push_pull_pol: assert property (@(posedge i_clock)
      disable iff (!i_reset_n)
      i_clk_en && pin_cfg[PIN_PUSH_PULL] && !irq_en[IE_FORCE_EN]
      |=> o_pin_oe && o_pin_out ==
          ($past(irq_level) ^ $past(pin_cfg[PIN_ACT_LOW])))
      else $error("Push-pull level ignores polarity");

   a_attach_sets: assert property (@(posedge i_clock)
      disable iff (!i_reset_n)
      i_clk_en && sync_b[0] && !evt_prev[0] && irq_en[IE_ATTACH]
      && sync_b[3] |=> irq_stat[IE_ATTACH])
      else $error("Attach event lost");

   a_ovp_gated: assert property (@(posedge i_clock)
      disable iff (!i_reset_n)
      !irq_en[IE_OVERVOLT] && !irq_stat[IE_OVERVOLT]
      |=> !irq_stat[IE_OVERVOLT])
      else $error("Overvoltage raised while disabled");

   a_host_sleep: assert property (@(posedge i_clock)
      disable iff (!i_reset_n)
      i_clk_en && sync_b[5] && !lp_ctrl[LP_HOST] |=> !o_frame_sleep)
      else $error("Host frame sleep while disabled");

   a_periph_sleep: assert property (@(posedge i_clock)
      disable iff (!i_reset_n)
      i_clk_en && !sync_b[5] && !lp_ctrl[LP_PERIPH] |=> !o_frame_sleep)
      else $error("Peripheral frame sleep while disabled");

   a_idle_thresh: assert property (@(posedge i_clock)
      disable iff (!i_reset_n)
      $rose(o_frame_sleep) |->
      $past(idle_cnt) >= idle_limit($past(lp_ctrl[LP_THR_HI:LP_THR_LO])))
      else $error("Frame sleep before idle threshold");

   a_resp_follow: assert property (@(posedge i_clock)
      disable iff (!i_reset_n)
      i_clk_en |=> o_response_sleep == $past(lp_ctrl[LP_RESP]))
      else $error("Response sleep not following enable");

   a_otp_load: assert property (@(posedge i_clock)
      disable iff (!i_reset_n)
      !$past(i_reset_n) |->
      lp_ctrl == (($past(i_otp_lp_default) & LP_WMASK) | LP_RSVD_VAL))
      else $error("Low-power defaults not loaded");

   a_reserved_fixed: assert property (@(posedge i_clock)
      disable iff (!i_reset_n)
      (lp_ctrl & ~LP_WMASK) == LP_RSVD_VAL && (irq_en & ~IE_WMASK) == 8'h00)
      else $error("Reserved bits changed");

endmodule : ielp_regs

// *** dv/ielp_regs_test.sv ***
// Self-checking bench for the interrupt-enable and low-power registers.
// Assumes ielp_pkg and ielp_regs compiled first; the bench drives all pins.

module ielp_regs_test;
   timeunit 1ns;
   timeprecision 1ps;
   import ielp_pkg::*;

   // =========================================================================
   // Signals
   localparam int FL = 64;
   logic        i_clock, i_reset_n, wb_cyc, wb_stb, wb_we, att, ovr, chg;
   logic        eds, idle, host, clk_en;
   logic [3:0]  wb_sel;
   logic [11:0] wb_adr;
   logic [31:0] wb_wdat, o_wb_dat;
   logic [7:0]  otp;
   logic        o_wb_ack, o_irq, o_pin_out, o_pin_oe, o_attach_watch;
   logic        o_frame_sleep, o_response_sleep;
   int          err_total, total_checks, n, t;
   logic [7:0]  q, r, lp_m;

   ielp_regs #(.FRAME_LEN(FL), .CNT_W(7)) uut
   (
      .i_clock(i_clock), .i_reset_n(i_reset_n), .i_clk_en(clk_en),
      .i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb), .i_wb_we(wb_we),
      .i_wb_adr(wb_adr), .i_wb_sel(wb_sel), .i_wb_dat(wb_wdat),
      .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_otp_lp_default(otp),
      .i_attach_seen(att), .i_overvoltage(ovr), .i_charger_found(chg),
      .i_eds_powered_down(eds), .i_bus_idle(idle), .i_host_role(host),
      .o_irq(o_irq), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe),
      .o_attach_watch(o_attach_watch), .o_frame_sleep(o_frame_sleep),
      .o_response_sleep(o_response_sleep)
   );

   initial
   begin
      i_clock = 1'b0;
      forever #5 i_clock = ~i_clock;
   end

   // =========================================================================
   // Shared tasks
   task complete_run;
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : complete_run

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e)
      begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // Classic cycle; the slave's latency is not assumed, only bounded
   task wb(input logic we, input logic [11:0] a, input logic [7:0] d);
      int k;
      wb_cyc  <= 1'b1;
      wb_stb  <= 1'b1;
      wb_we   <= we;
      wb_adr  <= a;
      wb_wdat <= {24'h0, d};
      k = 0;
      do
      begin
         @(posedge i_clock);
         k++;
      end
      while (o_wb_ack !== 1'b1 && k < 20);
      q = o_wb_dat[7:0];
      if (k >= 20)
      begin
         err_total++;
         $display("mismatch bus ack expected 1 seen none");
         complete_run();
      end
      chk("upper read bytes", 24'h0, o_wb_dat[31:8]);
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we  <= 1'b0;
      @(posedge i_clock);
   endtask : wb

   task rd_chk(input string nm, input logic [11:0] a, input logic [7:0] e);
      wb(1'b0, a, 8'h00);
      chk(nm, {24'h0, e}, {24'h0, q});
   endtask : rd_chk

   task pulse(input int k);
      if (k == 1) ovr <= 1'b1;
      else if (k == 3) att <= 1'b1;
      else chg <= 1'b1;
      repeat (4) @(posedge i_clock);
      ovr <= 1'b0;
      att <= 1'b0;
      chg <= 1'b0;
      repeat (4) @(posedge i_clock);
   endtask : pulse

   task do_reset;
      otp       <= 8'($urandom);
      i_reset_n <= 1'b0;
      repeat (2) @(posedge i_clock);
      i_reset_n <= 1'b1;
      @(posedge i_clock);
   endtask : do_reset

   // =========================================================================
   // Main sequence
   initial
   begin
      {i_reset_n, wb_cyc, wb_stb, wb_we, att, ovr, chg} = '0;
      {eds, idle, host, wb_adr, wb_wdat, otp} = '0;
      clk_en = 1'b1;
      wb_sel = 4'hf;
      err_total = 0;
      total_checks = 0;
      void'($urandom(32'ha1ea2be0));
      // Two resets, the second in mid-run, each with a fresh defaults word
      repeat (2)
      begin
         do_reset();
         lp_m = (otp & 8'hce) | 8'h20;
         rd_chk("ie reset", 12'h2d0, 8'h00);
         rd_chk("lp reset", 12'h2d4, lp_m);
         chk("resp sleep", lp_m[1], o_response_sleep);
         r = 8'($urandom);
         wb(1'b1, 12'h2d0, r);
         rd_chk("ie reserved", 12'h2d0, r & 8'hea);
         wb(1'b1, 12'h2d4, r);
         lp_m = (r & 8'hce) | 8'h20;
         rd_chk("lp reserved", 12'h2d4, lp_m);
         chk("resp sleep", lp_m[1], o_response_sleep);
      end
      wb(1'b1, 12'h3f0, 8'hff);
      rd_chk("unmapped", 12'h3f0, 8'h00);
      // A write without the low byte lane must not land
      wb(1'b1, 12'h2d0, 8'h00);
      wb_sel <= 4'he;
      wb(1'b1, 12'h2d0, 8'hea);
      wb_sel <= 4'hf;
      rd_chk("sel ignored", 12'h2d0, 8'h00);
      // Pin drive: every mode, polarity and forced level
      for (int m = 0; m < 8; m++)
      begin
         wb(1'b1, 12'h300, 8'(m >> 1));
         wb(1'b1, 12'h2d0, 8'h80 | 8'((m & 1) << 6));
         repeat (2) @(posedge i_clock);
         chk("pin oe", m[2] ? 1 : m[0], o_pin_oe);
         chk("pin out", m[2] ? m[0] ^ m[1] : 0, o_pin_out);
      end
      wb(1'b1, 12'h300, 8'h00);
      wb(1'b1, 12'h308, 8'h2a);
      rd_chk("mask", 12'h308, 8'h2a);
      // Events: disabled ones set nothing, enabled ones raise the level
      eds <= 1'b1;
      for (int k = 1; k < 6; k += 2)
      begin
         wb(1'b1, 12'h2d0, 8'h00);
         pulse(k);
         rd_chk("gated status", 12'h304, 8'h00);
         wb(1'b1, 12'h2d0, 8'(1 << k));
         repeat (2) @(posedge i_clock);
         chk("attach watch", k == 3, o_attach_watch);
         pulse(k);
         rd_chk("status", 12'h304, 8'(1 << k));
         chk("irq", 1, o_irq);
         chk("pin from irq", 1, o_pin_oe);
         wb(1'b1, 12'h308, 8'h00);
         repeat (2) @(posedge i_clock);
         chk("masked irq", 0, o_irq);
         // Push-pull from the interrupt itself, both polarities
         wb(1'b1, 12'h300, 8'h03);
         wb(1'b1, 12'h308, 8'h2a);
         repeat (2) @(posedge i_clock);
         chk("pp active low", 0, o_pin_out);
         wb(1'b1, 12'h300, 8'h02);
         repeat (2) @(posedge i_clock);
         chk("pp active high", 1, o_pin_out);
         wb(1'b1, 12'h300, 8'h00);
         wb(1'b1, 12'h2d0, 8'h80);
         repeat (2) @(posedge i_clock);
         chk("forced off", 0, o_pin_oe);
         wb(1'b1, 12'h304, 8'(1 << k));
         repeat (2) @(posedge i_clock);
         chk("irq cleared", 0, o_irq);
      end
      // Enable stays on: only the powered-up downstream side blocks attach
      wb(1'b1, 12'h2d0, 8'h08);
      eds <= 1'b0;
      repeat (4) @(posedge i_clock);
      chk("attach watch off", 0, o_attach_watch);
      pulse(3);
      rd_chk("attach powered", 12'h304, 8'h00);
      // Frame sleep threshold for every idle fraction code
      host <= 1'b1;
      for (int c = 0; c < 4; c++)
      begin
         wb(1'b1, 12'h2d4, 8'h80 | 8'(c << 2));
         repeat (4) @(posedge i_clock);
         idle <= 1'b1;
         n = 0;
         while (o_frame_sleep !== 1'b1 && n < 100)
         begin
            @(posedge i_clock);
            n++;
         end
         t = FL >> (5 - c);
         chk("sleep delay", t + 4, n);
         idle <= 1'b0;
         repeat (4) @(posedge i_clock);
         chk("sleep left", 0, o_frame_sleep);
      end
      // Peripheral role: host enable alone must not allow sleep
      host <= 1'b0;
      idle <= 1'b1;
      repeat (40) @(posedge i_clock);
      chk("periph off", 0, o_frame_sleep);
      wb(1'b1, 12'h2d4, 8'h40);
      repeat (8) @(posedge i_clock);
      chk("periph on", 1, o_frame_sleep);
      chk("resp off", 0, o_response_sleep);
      // Host role with only the peripheral enable set must not sleep
      host <= 1'b1;
      repeat (8) @(posedge i_clock);
      chk("host off", 0, o_frame_sleep);
      rd_chk("lp status", 12'h30c, 8'h04);
      // Clock enable low freezes the synchronisers and the sleep output
      clk_en <= 1'b0;
      host <= 1'b0;
      repeat (8) @(posedge i_clock);
      chk("frozen", 0, o_frame_sleep);
      clk_en <= 1'b1;
      repeat (8) @(posedge i_clock);
      chk("thawed", 1, o_frame_sleep);
      idle <= 1'b0;
      complete_run();
   end

   initial
   begin
      #1000000;
      err_total++;
      $display("mismatch run time expected done seen hang");
      complete_run();
   end

endmodule : ielp_regs_test
